// ---- core/ebctl_pkg.sv ----
package ebctl_pkg;
  // address and data widths of the external bus
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned N_WIN = 4;
  localparam int unsigned N_CS = 5;
  // demultiplexed low address lines
  localparam int unsigned LOW_ADDR_W = 16;
  // function cfg field positions
  localparam int unsigned FN_ENABLE = 0;
  localparam int unsigned FN_BUS16 = 1;
  localparam int unsigned FN_MUX = 2;
  localparam int unsigned FN_SEGW_LSB = 3;
  localparam int unsigned FN_SEGW_W = 3;
  localparam int unsigned FN_W = 6;
  // timing cfg field positions
  localparam int unsigned TM_ALE_LSB = 0;
  localparam int unsigned TM_CMD_LSB = 2;
  localparam int unsigned TM_W = 6;
  // reset values
  localparam logic [FN_W-1:0] FN_RESET = 6'h00;
  localparam logic [TM_W-1:0] TM_RESET = 6'h00;
  // segment line count 0..7 => 1 up to 8 ext lines
  localparam logic [2:0] SEGW_FULL = 3'h7;
  // reserved areas that go to the external bus
  localparam logic [ADDR_W-1:0] RSV_HI_BASE = 24'hf00000;
  localparam logic [ADDR_W-1:0] RSV_HI_END = 24'hfffeff;
  // on-chip module area on the internal bus
  localparam logic [ADDR_W-1:0] IPB_BASE = 24'h200000;
  localparam logic [ADDR_W-1:0] IPB_END = 24'h20ffff;

  // bus cycle phases, one-hot
  typedef enum logic [4:0] {
    EBCTL_IDLE = 5'h01,
    EBCTL_ADDR = 5'h02,
    EBCTL_CMD = 5'h04,
    EBCTL_WAIT = 5'h08,
    EBCTL_DONE = 5'h10
  } ebctl_state_e;
endpackage : ebctl_pkg

// ---- core/ebctl_ext_bus_ctrl.sv ----
// Summary of operation
// - single-chip mode or external bus mode
// - driven address width zero to 24 bits
// - data bus eight or sixteen bits
// - multiplexed or demultiplexed per configuration
// - demux puts low address on own lines
// - selectable segment lines limit external space
// - active-low selects per window plus default
// - timing and function configurable per region
// - ready input stretches slow accesses
// - ready active level is selectable
// - four address windows with own ranges
// - window four beats three, two beats one
// - outside all windows use default settings
// - only selected window asserts its select
// - bus timing follows reference clock rising edge
// - bus mode switches per selected window
// - also serves internal peripheral bus accesses
// - internal bus uses same protocol
// - about twelve megabytes external reachable
// - reserved areas become external accesses
module ebctl_ext_bus_ctrl
  import ebctl_pkg::*;
(
  clk_sys,
  reset,
  ext_bus_en,
  addr_width,
  rdy_active_high,
  window_range_lo,
  window_range_hi,
  window_function_cfg,
  window_timing_cfg,
  default_function_cfg,
  default_timing_cfg,
  req_valid,
  req_write,
  req_addr,
  req_wdata,
  req_ready,
  rsp_valid,
  rsp_rdata,
  bus_ref_clock_out,
  ready_pin,
  ad_out,
  ad_in,
  ad_oe_n,
  addr_hi_out,
  addr_lo_out,
  ale_out,
  rd_n_out,
  wr_n_out,
  cs_n_out,
  ipb_sel,
  ipb_ready,
  ipb_rdata,
  busy
);
  input wire logic clk_sys;
  input wire logic reset;
  input wire logic ext_bus_en; // 0: single-chip mode
  input wire logic [4:0] addr_width; // driven address bits 0..24
  input wire logic rdy_active_high; // ready polarity
  input wire logic [N_WIN*ADDR_W-1:0] window_range_lo;
  input wire logic [N_WIN*ADDR_W-1:0] window_range_hi;
  input wire logic [N_WIN*FN_W-1:0] window_function_cfg;
  input wire logic [N_WIN*TM_W-1:0] window_timing_cfg;
  input wire logic [FN_W-1:0] default_function_cfg;
  input wire logic [TM_W-1:0] default_timing_cfg;
  input wire logic req_valid;
  input wire logic req_write;
  input wire logic [ADDR_W-1:0] req_addr;
  input wire logic [DATA_W-1:0] req_wdata;
  output logic req_ready;
  output logic rsp_valid;
  output logic [DATA_W-1:0] rsp_rdata;
  output logic bus_ref_clock_out;
  input wire logic ready_pin; // async pin
  output logic [DATA_W-1:0] ad_out;
  input wire logic [DATA_W-1:0] ad_in; // async pins
  output logic ad_oe_n; // low while driving
  output logic [7:0] addr_hi_out;
  output logic [LOW_ADDR_W-1:0] addr_lo_out;
  output logic ale_out;
  output logic rd_n_out;
  output logic wr_n_out;
  output logic [N_CS-1:0] cs_n_out;
  output logic ipb_sel;
  input wire logic ipb_ready;
  input wire logic [DATA_W-1:0] ipb_rdata;
  output logic busy;

  // two-flop synchronisers for pins
  logic rdy_s1_reg, rdy_s2_reg;
  logic [DATA_W-1:0] ad_s1_reg, ad_s2_reg;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdy_s1_reg <= 1'b0;
      rdy_s2_reg <= 1'b0;
      ad_s1_reg <= '0;
      ad_s2_reg <= '0;
    end else begin
      rdy_s1_reg <= ready_pin;
      rdy_s2_reg <= rdy_s1_reg;
      ad_s1_reg <= ad_in;
      ad_s2_reg <= ad_s1_reg;
    end
  end

  // ready seen at its programmed level
  logic rdy_ok;
  assign rdy_ok = (rdy_s2_reg == rdy_active_high);

  // window hit per entry
  logic [N_WIN-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < N_WIN; g++) begin : g_win
      assign hit[g] = (req_addr >= window_range_lo[g*ADDR_W +: ADDR_W]) &&
        (req_addr <= window_range_hi[g*ADDR_W +: ADDR_W]);
    end
  endgenerate

  // priority select; index 0 is the default region
  logic [2:0] win_sel;
  always_comb begin
    // window 4 over 3, window 2 over 1
    if (hit[3]) win_sel = 3'h4;
    else if (hit[2]) win_sel = 3'h3;
    else if (hit[1]) win_sel = 3'h2;
    else if (hit[0]) win_sel = 3'h1;
    else win_sel = 3'h0;
  end

  // settings of the chosen region
  logic [FN_W-1:0] fn_sel;
  logic [TM_W-1:0] tm_sel;
  always_comb begin
    fn_sel = default_function_cfg;
    tm_sel = default_timing_cfg;
    if (win_sel != 3'h0) begin
      fn_sel = window_function_cfg[(win_sel-3'h1)*FN_W +: FN_W];
      tm_sel = window_timing_cfg[(win_sel-3'h1)*TM_W +: TM_W];
    end
  end

  // internal module area goes to the internal bus
  logic hit_ipb;
  assign hit_ipb = (req_addr >= IPB_BASE) && (req_addr <= IPB_END);

  // bus cycle state
  ebctl_state_e state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [2:0] cs_idx_reg, cs_idx_next;
  logic [FN_W-1:0] fn_reg, fn_next;
  logic [TM_W-1:0] tm_reg, tm_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [DATA_W-1:0] wdat_reg, wdat_next;
  logic wr_reg, wr_next;
  logic ipb_reg, ipb_next;
  logic [DATA_W-1:0] rdat_reg, rdat_next;
  logic rsp_reg, rsp_next;
  logic ref_reg, ref_next;

  // reference clock toggles every cycle; phases move on its rising edge
  logic ref_rise;
  assign ref_rise = ~ref_reg;

  // completion source: pin ready or internal ready, same protocol
  logic done_ok;
  assign done_ok = ipb_reg ? ipb_ready : rdy_ok;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cs_idx_next = cs_idx_reg;
    fn_next = fn_reg;
    tm_next = tm_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    wr_next = wr_reg;
    ipb_next = ipb_reg;
    rdat_next = rdat_reg;
    rsp_next = 1'b0;
    ref_next = ~ref_reg;
    case (state_reg)
      EBCTL_IDLE: begin
        // latch a request on a reference rising edge
        if (req_valid && ref_rise) begin
          // reserved high area still goes out as external access
          state_next = EBCTL_ADDR;
          cs_idx_next = win_sel;
          fn_next = fn_sel;
          tm_next = tm_sel;
          addr_next = req_addr;
          wdat_next = req_wdata;
          wr_next = req_write;
          ipb_next = hit_ipb || !ext_bus_en;
          cnt_next = tm_sel[TM_ALE_LSB +: 2];
        end
      end
      EBCTL_ADDR: begin
        // address phase length from timing cfg
        if (ref_rise) begin
          if (cnt_reg == 2'h0) begin
            state_next = EBCTL_CMD;
            cnt_next = tm_reg[TM_CMD_LSB +: 2];
          end else begin
            cnt_next = cnt_reg - 2'h1;
          end
        end
      end
      EBCTL_CMD: begin
        // programmed command delay, then wait for ready
        if (ref_rise) begin
          if (cnt_reg == 2'h0) state_next = EBCTL_WAIT;
          else cnt_next = cnt_reg - 2'h1;
        end
      end
      EBCTL_WAIT: begin
        // hold everything while ready is inactive
        if (ref_rise && done_ok) begin
          state_next = EBCTL_DONE;
          rdat_next = ipb_reg ? ipb_rdata : ad_s2_reg;
          if (!ipb_reg && !fn_reg[FN_BUS16]) begin
            rdat_next = {8'h00, ad_s2_reg[7:0]};
          end
        end
      end
      EBCTL_DONE: begin
        rsp_next = 1'b1;
        state_next = EBCTL_IDLE;
      end
      default: state_next = EBCTL_IDLE;
    endcase
  end

  // register the cycle state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= EBCTL_IDLE;
      cnt_reg <= 2'h0;
      cs_idx_reg <= 3'h0;
      fn_reg <= FN_RESET;
      tm_reg <= TM_RESET;
      addr_reg <= '0;
      wdat_reg <= '0;
      wr_reg <= 1'b0;
      ipb_reg <= 1'b0;
      rdat_reg <= '0;
      rsp_reg <= 1'b0;
      ref_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cs_idx_reg <= cs_idx_next;
      fn_reg <= fn_next;
      tm_reg <= tm_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      wr_reg <= wr_next;
      ipb_reg <= ipb_next;
      rdat_reg <= rdat_next;
      rsp_reg <= rsp_next;
      ref_reg <= ref_next;
    end
  end

  // pin drive decode; external only when not routed inside
  logic act, ext_act, mux_mode;
  logic [ADDR_W-1:0] amask;
  logic [7:0] segmask;
  assign act = (state_reg != EBCTL_IDLE) && (state_reg != EBCTL_DONE);
  assign ext_act = act && !ipb_reg && ext_bus_en;
  assign mux_mode = fn_reg[FN_MUX];
  // only the low addr_width bits are driven
  assign amask = (addr_width >= 5'h18) ? {ADDR_W{1'b1}} :
    ((24'h000001 << addr_width) - 24'h000001);
  // segment lines 16..23; fewer lines shrink space toward 128 KB
  assign segmask = 8'hff >> (SEGW_FULL - fn_reg[FN_SEGW_LSB +: FN_SEGW_W]);
  // 12 MB of 16 MB via A0..A23 with windows
  logic [ADDR_W-1:0] aout;
  assign aout = addr_reg & amask;

  // registered pin outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ad_out <= '0;
      ad_oe_n <= 1'b1;
      addr_hi_out <= 8'h00;
      addr_lo_out <= '0;
      ale_out <= 1'b0;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      cs_n_out <= '1;
      ipb_sel <= 1'b0;
    end else begin
      // freed segment lines stay low
      addr_hi_out <= ext_act ? (aout[23:16] & segmask) : 8'h00;
      addr_lo_out <= (ext_act && !mux_mode) ? aout[15:0] : '0;
      ale_out <= ext_act && (state_reg == EBCTL_ADDR);
      rd_n_out <= !(ext_act && !wr_reg && state_reg != EBCTL_ADDR);
      wr_n_out <= !(ext_act && wr_reg && state_reg != EBCTL_ADDR);
      // address then data on shared lines when multiplexed
      if (ext_act && mux_mode && state_reg == EBCTL_ADDR) begin
        ad_out <= aout[15:0];
        ad_oe_n <= 1'b0;
      end else if (ext_act && wr_reg && state_reg != EBCTL_ADDR) begin
        ad_out <= fn_reg[FN_BUS16] ? wdat_reg : {8'h00, wdat_reg[7:0]};
        ad_oe_n <= 1'b0;
      end else begin
        ad_out <= '0;
        ad_oe_n <= 1'b1;
      end
      // one low select, only for the latched region
      for (int i = 0; i < N_CS; i++) begin
        cs_n_out[i] <= !(ext_act && cs_idx_reg == i[2:0]);
      end
      ipb_sel <= act && ipb_reg;
    end
  end

  // handshake and status
  assign req_ready = (state_reg == EBCTL_IDLE) && ref_rise;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdat_reg;
  assign bus_ref_clock_out = ref_reg;
  assign busy = (state_reg != EBCTL_IDLE);
endmodule : ebctl_ext_bus_ctrl

// ---- test/ebctl_bus_monitor.sv ----
// pin-level checks on the controller, bound to every instance
module ebctl_bus_monitor
  import ebctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ext_bus_en,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic rsp_valid,
  input wire logic busy,
  input wire logic bus_ref_clock_out,
  input wire logic ad_oe_n,
  input wire logic [7:0] addr_hi_out,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic [N_CS-1:0] cs_n_out,
  input wire logic ipb_sel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a request taken on this edge
  sequence s_take;
    req_valid && req_ready;
  endsequence
  // internal bus area never reaches the pins
  sequence s_ext_take;
    s_take ##0 (ext_bus_en && !(req_addr >= IPB_BASE && req_addr <= IPB_END));
  endsequence
  one_select_a: assert property ($onehot0(~cs_n_out))
    else $error("more than one select low");
  single_chip_a: assert property (!ext_bus_en |-> &cs_n_out)
    else $error("select low in single-chip mode");
  ipb_quiet_a: assert property (ipb_sel |-> &cs_n_out)
    else $error("select low during internal access");
  ref_toggle_a: assert property (!$past(reset) |-> $changed(bus_ref_clock_out))
    else $error("reference clock stalled");
  take_edge_a: assert property (req_ready |-> !busy && !bus_ref_clock_out)
    else $error("request offered off the reference edge");
  sel_soon_a: assert property (s_ext_take |-> ##[1:3] !(&cs_n_out))
    else $error("no select after external request");
  wait_hold_a: assert property (!rd_n_out && $past(!rd_n_out) |->
    $stable(addr_hi_out) && $stable(cs_n_out))
    else $error("bus moved during read strobe");
  write_drive_a: assert property (!wr_n_out |-> !ad_oe_n)
    else $error("write strobe without data drive");
  read_float_a: assert property (!rd_n_out |-> ad_oe_n)
    else $error("data driven during read");
  rsp_bound_a: assert property (s_take |-> ##[4:600] rsp_valid)
    else $error("no response in time");
  hi_idle_a: assert property (&cs_n_out |-> addr_hi_out == 8'h00)
    else $error("segment lines driven with no select");
  ale_sel_a: assert property (ale_out |-> !(&cs_n_out) && rd_n_out && wr_n_out)
    else $error("address strobe outside a selected address phase");
endmodule : ebctl_bus_monitor

bind ebctl_ext_bus_ctrl ebctl_bus_monitor u_mon (.clk_sys, .reset,
  .ext_bus_en, .req_valid, .req_ready, .req_addr, .rsp_valid, .busy,
  .bus_ref_clock_out, .ad_oe_n, .addr_hi_out, .ale_out, .rd_n_out, .wr_n_out,
  .cs_n_out, .ipb_sel);

// ---- test/ebctl_far_mem.sv ----
// memories and peripherals sharing the external bus
module ebctl_far_mem
  import ebctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rdy_active_high,
  input wire logic [7:0] wait_n, // cycles before ready
  input wire logic [N_CS-1:0] cs_n_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic [DATA_W-1:0] ad_out,
  input wire logic [LOW_ADDR_W-1:0] addr_lo_out,
  output logic ready_pin,
  output logic [DATA_W-1:0] ad_in,
  output logic [2:0] sel_seen,
  output logic [DATA_W-1:0] wr_seen,
  output logic [LOW_ADDR_W-1:0] lo_seen
);
  logic [7:0] cnt; // cycles since select
  initial begin
    cnt = 8'h00;
    ready_pin = 1'b0;
    ad_in = 16'h0000;
    sel_seen = 3'h0;
  end
  // no pull on the data lines, so a released bus keeps toggling
  always @(posedge clk_sys) begin
    if (&cs_n_out) begin
      cnt <= 8'h00;
      ready_pin <= !rdy_active_high;
      ad_in <= ~ad_in;
    end else begin
      for (int i = 0; i < N_CS; i++)
        if (!cs_n_out[i]) sel_seen <= 3'(i);
      cnt <= cnt + 8'h01;
      // slow targets hold ready off first; ready only once the strobe is
      // low, so it never runs ahead of the data on the lines
      ready_pin <= (cnt >= wait_n && !(rd_n_out && wr_n_out)) ?
        rdy_active_high : !rdy_active_high;
      ad_in <= rd_n_out ? ~ad_in : (16'hc3a0 | 16'(sel_seen));
      if (!wr_n_out) begin
        wr_seen <= ad_out;
        lo_seen <= addr_lo_out;
      end
    end
  end
endmodule : ebctl_far_mem

// ---- test/ebctl_tb.sv ----
module tb
  import ebctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, reset = 1'b1, ext_bus_en = 1'b1, rdy_active_high = 1'b1;
  logic [4:0] addr_width = 5'h18;
  logic [N_WIN*ADDR_W-1:0] window_range_lo, window_range_hi;
  logic [N_WIN*FN_W-1:0] window_function_cfg;
  logic [N_WIN*TM_W-1:0] window_timing_cfg;
  logic [FN_W-1:0] default_function_cfg = 6'h3b;
  logic [TM_W-1:0] default_timing_cfg = 6'h00;
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, ipb_sel;
  logic [ADDR_W-1:0] req_addr = 24'h000000;
  logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, ad_out, ad_in, wr_seen;
  logic [DATA_W-1:0] ipb_rdata = 16'h1b2d; // internal module data
  logic ipb_ready = 1'b0, ready_pin, rd_n_out, wr_n_out;
  logic [LOW_ADDR_W-1:0] addr_lo_out, lo_seen;
  logic [N_CS-1:0] cs_n_out;
  logic [7:0] wait_n = 8'h00;
  logic [2:0] sel_seen;
  int miscompares = 0, num_checks = 0;
  // windows 1..4: 16 demux, 8 mux, 16 mux, 8 demux; 2 inside 1, 4 inside 3
  initial begin
    window_range_lo = {24'h480000, 24'h400000, 24'h018000, 24'h010000};
    window_range_hi = {24'h48ffff, 24'h4fffff, 24'h018fff, 24'h01ffff};
    window_function_cfg = {6'h39, 6'h3f, 6'h3d, 6'h3b};
    window_timing_cfg = {6'h0f, 6'h0a, 6'h05, 6'h00};
  end
  always #20 clk_sys = ~clk_sys;
  // internal modules answer one cycle after selection
  always @(posedge clk_sys) ipb_ready <= ipb_sel;
  ebctl_ext_bus_ctrl u_dut (.clk_sys, .reset, .ext_bus_en, .addr_width,
    .rdy_active_high, .window_range_lo, .window_range_hi,
    .window_function_cfg, .window_timing_cfg, .default_function_cfg,
    .default_timing_cfg, .req_valid, .req_write, .req_addr, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .bus_ref_clock_out(), .ready_pin,
    .ad_out, .ad_in, .ad_oe_n(), .addr_hi_out(), .addr_lo_out, .ale_out(),
    .rd_n_out, .wr_n_out, .cs_n_out, .ipb_sel, .ipb_ready, .ipb_rdata,
    .busy());
  ebctl_far_mem u_mem (.clk_sys, .rdy_active_high, .wait_n, .cs_n_out,
    .rd_n_out, .wr_n_out, .ad_out, .addr_lo_out, .ready_pin, .ad_in,
    .sel_seen, .wr_seen, .lo_seen);
  task automatic chk(string what, logic [23:0] got, logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one transfer; n counts cycles from take to response
  task automatic access(logic w, logic [23:0] a, logic [15:0] d,
                        output logic [15:0] q, output int n);
    n = 0;
    @(posedge clk_sys);
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_valid <= 1'b1;
    forever begin
      @(negedge clk_sys);
      if (req_ready === 1'b1) break;
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    q = rsp_rdata;
    chk("response", 24'(n < 2000), 24'h000001);
    // hand back on a rising edge so callers drive inputs there
    @(posedge clk_sys);
  endtask : access
  // each window, overlaps, default and a reserved area
  task automatic t_windows;
    logic [23:0] ad [6] = '{24'h010100, 24'h018010, 24'h410000,
                            24'h480004, 24'h100000, 24'hf00010};
    logic [2:0] sel [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
    logic [15:0] q, exp;
    int n;
    for (int i = 0; i < 6; i++) begin
      access(1'b0, ad[i], 16'h0000, q, n);
      chk("select", 24'(sel_seen), 24'(sel[i]));
      exp = 16'hc3a0 | 16'(sel[i]);
      if (sel[i] == 3'h2 || sel[i] == 3'h4) exp[15:8] = 8'h00;
      chk("read data", 24'(q), 24'(exp));
    end
    $display("done windows");
  endtask : t_windows
  // demux write puts the low address on its own lines
  task automatic t_write;
    logic [15:0] q;
    int n;
    access(1'b1, 24'h012468, 16'h9e71, q, n);
    chk("write data", 24'(wr_seen), 24'h009e71);
    chk("low address", 24'(lo_seen), 24'h002468);
    // only eight address bits driven
    addr_width <= 5'h08;
    access(1'b1, 24'h012468, 16'h9e71, q, n);
    chk("narrow address", 24'(lo_seen), 24'h000068);
    addr_width <= 5'h18;
    $display("done write");
  endtask : t_write
  // low-active ready held off by a slow target
  task automatic t_ready;
    logic [15:0] q;
    int n;
    rdy_active_high <= 1'b0;
    wait_n <= 8'd20;
    access(1'b0, 24'h010100, 16'h0000, q, n);
    chk("slow data", 24'(q), 24'h00c3a1);
    chk("slow waited", 24'(n >= 20), 24'h000001);
    rdy_active_high <= 1'b1;
    wait_n <= 8'h00;
    $display("done ready");
  endtask : t_ready
  // internal bus area, then single-chip mode
  task automatic t_internal;
    logic [15:0] q;
    int n;
    access(1'b0, 24'h200010, 16'h0000, q, n);
    chk("internal data", 24'(q), 24'h001b2d);
    ext_bus_en <= 1'b0;
    access(1'b0, 24'h010100, 16'h0000, q, n);
    chk("single-chip data", 24'(q), 24'h001b2d);
    ext_bus_en <= 1'b1;
    $display("done internal");
  endtask : t_internal
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_windows();
    t_write();
    t_ready();
    t_internal();
    close_out();
  end
endmodule : tb
